// >>> hdl/motion_regs_pkg.sv
// constants and types shared by the motion sensor register group
package motion_regs_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [6:0] AXIS_STANDBY_CONTROL_OFS = 7'h6C;
  localparam logic [6:0] SERIAL_PORT_SELECT_OFS   = 7'h70;
  localparam logic [6:0] QUEUE_LEVEL_HIGH_OFS     = 7'h72;
  localparam logic [6:0] QUEUE_LEVEL_LOW_OFS      = 7'h73;
  localparam logic [6:0] QUEUE_DATA_PORT_OFS      = 7'h74;
  localparam logic [6:0] DEVICE_IDENTITY_OFS      = 7'h75;
  // index 0 is x, 1 is y, 2 is z
  localparam logic [2:0][6:0] TRIM_HIGH_OFS = {7'h7D, 7'h7A, 7'h77};
  localparam logic [2:0][6:0] TRIM_LOW_OFS  = {7'h7E, 7'h7B, 7'h78};

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int STANDBY_MSB          = 5;
  localparam int STANDBY_LSB          = 0;
  localparam int TWO_WIRE_DISABLE_BIT = 6;
  localparam int TRIM_HIGH_LSB        = 7;
  localparam int TRIM_LOW_MSB         = 7;
  localparam int TRIM_LOW_LSB         = 1;
  localparam int CMD_READ_BIT         = 7;

  // ************************************************************
  // reset values and codes
  // ************************************************************
  localparam logic [5:0]  STANDBY_RST        = 6'h00;
  localparam logic        PORT_DISABLE_RST   = 1'b0;
  localparam logic [14:0] TRIM_RST           = 15'h0000;
  localparam logic [7:0]  EMPTY_MARKER       = 8'hFF;
  localparam logic [7:0]  PAYLOAD_CEILING    = 8'hFE;
  localparam logic [5:0]  TWO_WIRE_ADDR_HIGH = 6'h34;
  localparam int          SENSOR_BYTES       = 14;
  localparam int          FIRST_SENSOR_REG   = 59;
  localparam int          TRIM_STEP_UG       = 980;
  localparam int          TRIM_SPAN_G        = 16;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS     = 25;
  localparam int INT_CLK_PERIOD_NS = 50;
  localparam int QUEUE_RST_CYCLES  = (INT_CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum {SER_CMD, SER_DATA} ser_type;

  typedef struct packed {
    logic accel_x_off;
    logic accel_y_off;
    logic accel_z_off;
    logic gyro_x_off;
    logic gyro_y_off;
    logic gyro_z_off;
  } standby_type;

  typedef struct packed {
    logic [14:0] accel_z_trim;
    logic [14:0] accel_y_trim;
    logic [14:0] accel_x_trim;
  } trim_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic addr_sel;
  } pin_type;

  localparam pin_type PIN_IDLE = '{sclk: 1'b1, cs_n: 1'b1, mosi: 1'b0, addr_sel: 1'b0};

endpackage

// >>> hdl/queue_store.sv
// byte storage of the sample queue with registered read data
`timescale 1ns/10ps
module queue_store
  import motion_regs_pkg::*;
#(
  parameter int WIDTH  = 8,
  parameter int ADDR_W = 9
) (
  // clock
  input  wire logic              clk,
  // write side
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [WIDTH-1:0]  wdata,
  // read side
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [WIDTH-1:0]  rdata_q
);

  logic [WIDTH-1:0] mem_q [2**ADDR_W];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_q <= mem_q[raddr];
  end

endmodule

// >>> hdl/motion_regs.sv
// serial register port, sample queue, standby, identity and trim registers
`timescale 1ns/10ps
// Behaviour
// (R1) accel standby bits 5..3 switch x,y,z accelerometer off when set
// (R2) gyro standby bits 2..0 switch x,y,z gyro off when set
// (R3) bit 6 of port select shuts the two-wire slave, serial port SPI only
// (R4) 16-bit queue byte count readable as high and low byte
// (R5) reading high count byte snapshots whole count into both bytes
// (R6) host reads low count byte to latch fresh count
// (R7) data port read pops one byte, write pushes one byte
// (R8) sample bytes enter queue in ascending register order
// (R9) each sample tick copies enabled bytes of registers 59..72 into queue; a tick during a capture walk is ignored
// (R10) overflow sets the sticky overflow status flag
// (R11) when full, drop oldest unless stop-when-full is set
// (R12) empty queue read returns 0xFF until data arrives
// (R13) payload bytes never equal 0xFF
// (R14) identity register returns fixed 8-bit code
// (R15) two-wire address 0x68 or 0x69 by address-select pin
// (R16) 15-bit trims: high holds 14..7, low bits 7..1 hold 6..0
// (R17) trim step 0.98 mg over +-16 g in every range
// (R18) queue works only while enabled, else port access disabled
// (R19) queue reset clears queue and self-clears after one 20 MHz cycle
// (R20) host uses byte registers by address, reserved bits write zero
module motion_regs
  import motion_regs_pkg::*;
#(
  parameter int         DEPTH    = 512,
  parameter logic [7:0] IDENTITY = 8'h5A  // arbitrary code
) (
  // clock and reset
  input  wire logic                          CLK,
  input  wire logic                          NRST,
  // serial pins
  input  wire logic                          SCLK,
  input  wire logic                          CS_N,
  input  wire logic                          MOSI,
  output logic                               MISO,
  output logic                               MISO_OE_N,
  // two-wire slave control
  input  wire logic                          ADDRESS_SELECT_PIN,
  output logic                               TWO_WIRE_ENABLE,
  output logic      [6:0]                    TWO_WIRE_ADDRESS,
  // sensor capture
  input  wire logic                          SAMPLE_TICK,
  input  wire logic [SENSOR_BYTES-1:0][7:0]  SENSOR_DATA,
  input  wire logic [SENSOR_BYTES-1:0]       CAPTURE_EN,
  // queue control and status
  input  wire logic                          QUEUE_ENABLE,
  input  wire logic                          QUEUE_RESET,
  input  wire logic                          STOP_WHEN_FULL,
  input  wire logic                          OVERFLOW_CLEAR,
  output logic                               QUEUE_OVERFLOW_FLAG,
  // sensor controls
  output standby_type                        STANDBY_CTRL,
  output trim_type                           ACCEL_TRIM
);

  localparam int          AW      = $clog2(DEPTH);
  localparam logic [15:0] DEPTH_L = 16'(DEPTH);

  // ************************************************************
  // pin synchroniser
  // ************************************************************
  pin_type pin_a_q;
  pin_type pin_b_q;
  logic    sclk_old_q;
  logic    sclk_rise;
  logic    sclk_fall;
  logic    cs_act;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pin_a_q    <= PIN_IDLE;
      pin_b_q    <= PIN_IDLE;
      sclk_old_q <= 1'b1;
    end else begin
      pin_a_q    <= '{sclk: SCLK, cs_n: CS_N, mosi: MOSI, addr_sel: ADDRESS_SELECT_PIN};
      pin_b_q    <= pin_a_q;
      sclk_old_q <= pin_b_q.sclk;
    end
  end

  assign cs_act    = !pin_b_q.cs_n;
  assign sclk_rise = cs_act && pin_b_q.sclk && !sclk_old_q;
  assign sclk_fall = cs_act && !pin_b_q.sclk && sclk_old_q;

  // ************************************************************
  // serial frame engine
  // ************************************************************
  ser_type    ser_q;
  logic [2:0] bit_q;
  logic [7:0] in_q;
  logic [7:0] out_q;
  logic [6:0] addr_q;
  logic       rd_q;
  logic       load_q;
  logic [7:0] in_byte;
  logic       byte_done;
  logic       wr_now;
  logic       load_now;
  logic [7:0] rd_value;

  assign in_byte   = {in_q[6:0], pin_b_q.mosi};
  assign byte_done = sclk_rise && bit_q == 3'h7;
  assign wr_now    = byte_done && ser_q == SER_DATA && !rd_q;
  assign load_now  = sclk_fall && load_q;

  always_ff @(posedge CLK) begin
    if (!NRST || !cs_act) begin
      ser_q  <= SER_CMD;
      bit_q  <= 3'h0;
      in_q   <= 8'h00;
      addr_q <= 7'h00;
      rd_q   <= 1'b0;
      load_q <= 1'b0;
    end else begin
      if (sclk_rise) begin
        in_q  <= in_byte;
        bit_q <= bit_q + 3'h1;
      end
      if (byte_done && ser_q == SER_CMD) begin
        ser_q  <= SER_DATA;
        addr_q <= in_byte[6:0];
        rd_q   <= in_byte[CMD_READ_BIT];
        load_q <= in_byte[CMD_READ_BIT];
      end else if (byte_done) begin
        load_q <= rd_q;
        if (!rd_q && addr_q != QUEUE_DATA_PORT_OFS) begin
          addr_q <= addr_q + 7'h01;
        end
      end else if (load_now) begin
        load_q <= 1'b0;
        if (addr_q != QUEUE_DATA_PORT_OFS) begin
          addr_q <= addr_q + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      out_q <= 8'h00;
    end else if (load_now) begin
      out_q <= rd_value;
    end else if (sclk_fall) begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign MISO      = out_q[7];
  assign MISO_OE_N = !(cs_act && ser_q == SER_DATA && rd_q);

  // ************************************************************
  // control registers
  // ************************************************************
  standby_type      standby_q;
  logic             port_dis_q;
  logic [2:0][14:0] trim_q;
  logic [6:0]       two_wire_addr_q;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      standby_q  <= STANDBY_RST;
      port_dis_q <= PORT_DISABLE_RST;
      trim_q     <= {3{TRIM_RST}};
    end else if (wr_now) begin
      if (addr_q == AXIS_STANDBY_CONTROL_OFS) begin
        standby_q <= in_byte[STANDBY_MSB:STANDBY_LSB]; // R1 R2 R20
      end else if (addr_q == SERIAL_PORT_SELECT_OFS) begin
        port_dis_q <= in_byte[TWO_WIRE_DISABLE_BIT]; // R3
      end
      for (int i = 0; i < 3; i++) begin
        if (addr_q == TRIM_HIGH_OFS[i]) begin
          trim_q[i][14:TRIM_HIGH_LSB] <= in_byte; // R16
        end else if (addr_q == TRIM_LOW_OFS[i]) begin
          trim_q[i][TRIM_HIGH_LSB-1:0] <= in_byte[TRIM_LOW_MSB:TRIM_LOW_LSB]; // R16
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      two_wire_addr_q <= {TWO_WIRE_ADDR_HIGH, 1'b0};
    end else begin
      two_wire_addr_q <= {TWO_WIRE_ADDR_HIGH, pin_b_q.addr_sel}; // R15
    end
  end

  assign STANDBY_CTRL     = standby_q; // R1 R2
  assign TWO_WIRE_ENABLE  = !port_dis_q; // R3
  assign TWO_WIRE_ADDRESS = two_wire_addr_q;
  // trim codes pass straight on, one step of TRIM_STEP_UG over TRIM_SPAN_G
  assign ACCEL_TRIM       = trim_q; // R17

  // ************************************************************
  // sample capture sequencer
  // ************************************************************
  logic                          busy_q;
  logic [3:0]                    idx_q;
  logic [SENSOR_BYTES-1:0][7:0]  cap_data_q;
  logic [SENSOR_BYTES-1:0]       cap_mask_q;
  logic                          seq_push;
  logic                          q_rst;

  always_ff @(posedge CLK) begin
    if (!NRST || q_rst) begin
      busy_q     <= 1'b0;
      idx_q      <= 4'h0;
      cap_mask_q <= '0;
    end else if (SAMPLE_TICK && QUEUE_ENABLE && !busy_q) begin
      busy_q     <= 1'b1; // R9
      idx_q      <= 4'h0;
      cap_mask_q <= CAPTURE_EN;
    end else if (busy_q) begin
      idx_q <= idx_q + 4'h1; // R8
      if (idx_q == 4'(SENSOR_BYTES - 1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SAMPLE_TICK && !busy_q) begin
      cap_data_q <= SENSOR_DATA;
    end
  end

  assign seq_push = busy_q && cap_mask_q[idx_q] && QUEUE_ENABLE; // R9 R18

  // ************************************************************
  // queue engine
  // ************************************************************
  logic [1:0]    qrst_cnt_q;
  logic          hp_q;
  logic [7:0]    hp_data_q;
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [15:0]   level_q;
  logic [15:0]   level_snap_q;
  logic [7:0]    rd_data;
  logic [7:0]    push_raw;
  logic [7:0]    push_byte;
  logic          push_req;
  logic          pop_ok;
  logic          full;
  logic          empty;
  logic          ovf;
  logic          do_write;
  logic          drop_old;
  logic [AW-1:0] rd_next;
  logic          byp_q;
  logic [7:0]    byp_data_q;
  logic [7:0]    head;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      qrst_cnt_q <= 2'h0;
    end else if (QUEUE_RESET) begin
      qrst_cnt_q <= 2'(QUEUE_RST_CYCLES); // R19
    end else if (qrst_cnt_q != 2'h0) begin
      qrst_cnt_q <= qrst_cnt_q - 2'h1; // R19
    end
  end

  assign q_rst = qrst_cnt_q != 2'h0;

  always_ff @(posedge CLK) begin
    if (!NRST || q_rst) begin
      hp_q      <= 1'b0;
      hp_data_q <= 8'h00;
    end else if (wr_now && addr_q == QUEUE_DATA_PORT_OFS && QUEUE_ENABLE) begin
      hp_q      <= 1'b1; // R7
      hp_data_q <= in_byte;
    end else if (!seq_push) begin
      hp_q <= 1'b0;
    end
  end

  assign full      = level_q == DEPTH_L;
  assign empty     = level_q == 16'h0000;
  assign push_req  = seq_push || (hp_q && QUEUE_ENABLE); // R18
  assign push_raw  = seq_push ? cap_data_q[idx_q] : hp_data_q;
  assign push_byte = (push_raw == EMPTY_MARKER) ? PAYLOAD_CEILING : push_raw; // R13
  assign pop_ok    = load_now && addr_q == QUEUE_DATA_PORT_OFS && QUEUE_ENABLE && !empty; // R7
  assign ovf       = push_req && full && !pop_ok;
  assign do_write  = push_req && !(ovf && STOP_WHEN_FULL); // R11
  assign drop_old  = ovf && !STOP_WHEN_FULL; // R11
  assign rd_next   = rd_ptr_q + AW'(pop_ok || drop_old);

  always_ff @(posedge CLK) begin
    if (!NRST || q_rst) begin
      wr_ptr_q <= '0; // R19
      rd_ptr_q <= '0;
      level_q  <= 16'h0000;
    end else begin
      if (do_write) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop_ok || drop_old) begin
        rd_ptr_q <= rd_ptr_q + AW'(1); // R11
      end
      level_q <= level_q + 16'(do_write && !drop_old) - 16'(pop_ok); // R4
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      QUEUE_OVERFLOW_FLAG <= 1'b0;
    end else if (ovf) begin
      QUEUE_OVERFLOW_FLAG <= 1'b1; // R10
    end else if (OVERFLOW_CLEAR) begin
      QUEUE_OVERFLOW_FLAG <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      level_snap_q <= 16'h0000;
    end else if (load_now && addr_q == QUEUE_LEVEL_HIGH_OFS) begin
      level_snap_q <= level_q; // R5
    end else if (load_now && addr_q == QUEUE_LEVEL_LOW_OFS) begin
      level_snap_q <= level_q; // R6
    end
  end

  // byte written into the head slot bypasses the registered read
  always_ff @(posedge CLK) begin
    if (!NRST || q_rst) begin
      byp_q      <= 1'b0;
      byp_data_q <= 8'h00;
    end else begin
      byp_q      <= do_write && wr_ptr_q == rd_next;
      byp_data_q <= push_byte;
    end
  end

  assign head = byp_q ? byp_data_q : rd_data;

  queue_store #(
    .WIDTH  (8),
    .ADDR_W (AW)
  ) u_store (
    .clk     (CLK),
    .we      (do_write),
    .waddr   (wr_ptr_q),
    .wdata   (push_byte),
    .raddr   (rd_next),
    .rdata_q (rd_data)
  );

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    rd_value = 8'h00;
    if (addr_q == AXIS_STANDBY_CONTROL_OFS) begin
      rd_value[STANDBY_MSB:STANDBY_LSB] = standby_q;
    end else if (addr_q == SERIAL_PORT_SELECT_OFS) begin
      rd_value[TWO_WIRE_DISABLE_BIT] = port_dis_q;
    end else if (addr_q == QUEUE_LEVEL_HIGH_OFS) begin
      rd_value = level_q[15:8]; // R4 R5
    end else if (addr_q == QUEUE_LEVEL_LOW_OFS) begin
      rd_value = level_snap_q[7:0]; // R4 R6
    end else if (addr_q == QUEUE_DATA_PORT_OFS) begin
      rd_value = (QUEUE_ENABLE && !empty) ? head : EMPTY_MARKER; // R12 R18
    end else if (addr_q == DEVICE_IDENTITY_OFS) begin
      rd_value = IDENTITY; // R14
    end
    for (int i = 0; i < 3; i++) begin
      if (addr_q == TRIM_HIGH_OFS[i]) begin
        rd_value = trim_q[i][14:TRIM_HIGH_LSB];
      end else if (addr_q == TRIM_LOW_OFS[i]) begin
        rd_value = {trim_q[i][TRIM_HIGH_LSB-1:0], 1'b0};
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  a_standby_write: assert property ( // R1
    wr_now && addr_q == AXIS_STANDBY_CONTROL_OFS
      |=> {2'b00, STANDBY_CTRL} == ($past(in_byte) & 8'h3F))
    else $error("standby bits not taken from write");

  a_port_disable: assert property ( // R3
    wr_now && addr_q == SERIAL_PORT_SELECT_OFS && in_byte[TWO_WIRE_DISABLE_BIT]
      |=> !TWO_WIRE_ENABLE)
    else $error("two-wire port still enabled");

  a_level_push: assert property ( // R4
    push_req && !full && !pop_ok && !q_rst |=> level_q == $past(level_q) + 16'h0001)
    else $error("level did not count push");

  a_count_snap: assert property ( // R5
    load_now && addr_q == QUEUE_LEVEL_HIGH_OFS |=> level_snap_q == $past(level_q))
    else $error("count snapshot not taken");

  a_capture_walk: assert property ( // R9
    $rose(busy_q) |-> busy_q [*8] ##1 busy_q [*6] ##1 !busy_q)
    else $error("capture walk not fourteen cycles");

  a_overflow_sets: assert property ( // R10
    ovf |=> QUEUE_OVERFLOW_FLAG)
    else $error("overflow flag not set");

  a_stop_full: assert property ( // R11
    ovf && STOP_WHEN_FULL && !q_rst |=> level_q == $past(level_q) && wr_ptr_q == $past(wr_ptr_q))
    else $error("full queue overwritten in stop mode");

  a_drop_oldest: assert property ( // R11
    ovf && !STOP_WHEN_FULL && !q_rst |=> rd_ptr_q == $past(rd_ptr_q) + AW'(1))
    else $error("oldest byte not dropped");

  a_empty_marker: assert property ( // R12
    load_now && addr_q == QUEUE_DATA_PORT_OFS && empty |=> out_q == EMPTY_MARKER && MISO)
    else $error("empty read did not give marker");

  a_payload_clean: assert property ( // R13
    do_write |-> push_byte != EMPTY_MARKER)
    else $error("payload equals empty marker");

  a_identity_read: assert property ( // R14
    load_now && addr_q == DEVICE_IDENTITY_OFS |=> out_q == IDENTITY)
    else $error("identity code wrong");

  a_disabled_idle: assert property ( // R18
    !QUEUE_ENABLE |-> !push_req && !pop_ok)
    else $error("queue moved while disabled");

  a_reset_clears: assert property ( // R19
    $rose(q_rst) |=> level_q == 16'h0000 ##1 level_q == 16'h0000 && !q_rst)
    else $error("queue reset did not clear");

endmodule

// >>> sim/spi_host_model.sv
// host serial master model for the register port
`timescale 1ns/10ps
module spi_host_model (
  // pacing clock
  input  wire logic clk,
  // serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe_n
);
  logic [7:0] tx [32];
  logic [7:0] rx [32];
  logic [7:0] rx_byte;
  logic       last_q;
  logic       line;
  event       got;

  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
    last_q = 1'b0;
  end
  always @(posedge clk) begin
    if (!miso_oe_n) last_q <= miso;
  end
  // released line shows inverse of last bit
  assign line = miso_oe_n ? ~last_q : miso;

  // ******
  // frames
  // ******
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic xbyte(input logic [7:0] o, output logic [7:0] i);
    for (int b = 7; b >= 0; b--) begin
      sclk = 1'b0;
      mosi = o[b];
      half();
      sclk = 1'b1;
      i[b] = line;
      half();
    end
  endtask
  // one byte address then n data bytes
  task automatic frame(input logic [7:0] cmd, input int n);
    logic [7:0] d;
    cs_n = 1'b0;
    half();
    xbyte(cmd, d);
    for (int k = 0; k < n; k++) begin
      xbyte(tx[k], rx[k]);
      if (cmd[7]) begin
        rx_byte = rx[k];
        ->got;
      end
    end
    cs_n = 1'b1;
    half();
    half();
  endtask
endmodule

// >>> sim/motion_regs_tb.sv
// self-checking bench for the motion sensor register group
`timescale 1ns/10ps
module motion_regs_tb
  import motion_regs_pkg::*;
;
  localparam int         DEPTH   = 16;
  localparam logic [7:0] ID_CODE = 8'hA6; // arbitrary code
  logic                          clk, nrst, miso, miso_oe_n, sclk, cs_n, mosi;
  logic                          adr_sel, tick, q_en, q_rst, stop_full, ovf_clr;
  logic                          two_en, ovf, ovf_exp;
  logic      [6:0]               two_addr;
  logic      [SENSOR_BYTES-1:0][7:0] sdata;
  logic      [SENSOR_BYTES-1:0]  cap_en;
  standby_type                   stby;
  trim_type                      trim;
  logic      [7:0]               exp_q [$];
  logic      [7:0]               fq [$];
  int                            fails, compares;
  int                            seed = 3;

  motion_regs #(.DEPTH(DEPTH), .IDENTITY(ID_CODE)) dut (
    .CLK(clk), .NRST(nrst), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso),
    .MISO_OE_N(miso_oe_n), .ADDRESS_SELECT_PIN(adr_sel), .TWO_WIRE_ENABLE(two_en),
    .TWO_WIRE_ADDRESS(two_addr), .SAMPLE_TICK(tick), .SENSOR_DATA(sdata),
    .CAPTURE_EN(cap_en), .QUEUE_ENABLE(q_en), .QUEUE_RESET(q_rst),
    .STOP_WHEN_FULL(stop_full), .OVERFLOW_CLEAR(ovf_clr),
    .QUEUE_OVERFLOW_FLAG(ovf), .STANDBY_CTRL(stby), .ACCEL_TRIM(trim));
  spi_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n));

  // *******
  // helpers
  // *******
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    host.tx[0] = v;
    host.frame({1'b0, a}, 1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.frame({1'b1, a}, 1);
  endtask
  function automatic void push_b(input logic [7:0] b);
    if (fq.size() == DEPTH) begin
      ovf_exp = 1'b1;
      if (stop_full) return;
      void'(fq.pop_front());
    end
    fq.push_back(b == EMPTY_MARKER ? PAYLOAD_CEILING : b);
  endfunction
  task automatic drain(input int n);
    for (int k = 0; k < n; k++) exp_q.push_back(fq.size() ? fq.pop_front() : EMPTY_MARKER);
    host.frame({1'b1, QUEUE_DATA_PORT_OFS}, n);
  endtask
  task automatic level();
    exp_q.push_back(8'(fq.size() >> 8));
    exp_q.push_back(8'(fq.size()));
    host.frame({1'b1, QUEUE_LEVEL_HIGH_OFS}, 2);
  endtask
  task automatic sample();
    for (int k = 0; k < SENSOR_BYTES; k++) sdata[k] = 8'($random(seed));
    sdata[3] = 8'hFF;
    for (int k = 0; k < SENSOR_BYTES; k++) if (cap_en[k]) push_b(sdata[k]);
    tick = 1'b1;
    step(1);
    tick = 1'b0;
    step(20);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #2000000;
    fails++;
    final_report();
  end
  initial forever begin
    @(host.got);
    cmp("read byte", exp_q.size() ? exp_q.pop_front() : 8'hxx, host.rx_byte);
  end

  // *********
  // scenarios
  // *********
  initial begin
    logic [7:0] v;
    logic [7:0] w;
    {nrst, adr_sel, tick, q_rst, stop_full, ovf_clr, ovf_exp} = '0;
    q_en = 1'b1;
    cap_en = '0;
    sdata = '0;
    step(16);
    nrst = 1'b1;
    step(4);
    cmp("standby", STANDBY_RST, stby);
    cmp("two wire en", 1'b1, two_en);
    cmp("two wire addr", 7'h68, two_addr);
    cmp("miso drive", 1'b1, miso_oe_n);
    rd(DEVICE_IDENTITY_OFS, ID_CODE);
    drain(2);
    rd(7'h01, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed)) & 8'h3F;
      wr(AXIS_STANDBY_CONTROL_OFS, v);
      cmp("standby", v[5:0], stby);
      rd(AXIS_STANDBY_CONTROL_OFS, v);
    end
    wr(SERIAL_PORT_SELECT_OFS, 8'h40);
    cmp("two wire en", 1'b0, two_en);
    adr_sel = 1'b1;
    wr(SERIAL_PORT_SELECT_OFS, 8'h00);
    cmp("two wire en", 1'b1, two_en);
    cmp("two wire addr", 7'h69, two_addr);
    for (int a = 0; a < 3; a++) begin
      v = 8'($random(seed));
      w = 8'($random(seed));
      host.tx[0] = v;
      host.tx[1] = w;
      host.frame({1'b0, TRIM_HIGH_OFS[a]}, 2);
      cmp("trim", {1'b0, v, w[7:1]}, 16'(trim[a*15 +: 15]));
      exp_q.push_back(v);
      exp_q.push_back({w[7:1], 1'b0});
      host.frame({1'b1, TRIM_HIGH_OFS[a]}, 2);
    end
    cap_en = 14'($random(seed)) | 14'h0008;
    sample();
    level();
    drain(fq.size() + 1);
    for (int k = 0; k < 3; k++) begin
      host.tx[k] = 8'($random(seed)) & 8'h7F;
      push_b(host.tx[k]);
    end
    host.frame({1'b0, QUEUE_DATA_PORT_OFS}, 3);
    drain(3);
    wr(QUEUE_DATA_PORT_OFS, 8'h21);
    push_b(8'h21);
    q_en = 1'b0;
    wr(QUEUE_DATA_PORT_OFS, 8'h22);
    rd(QUEUE_DATA_PORT_OFS, EMPTY_MARKER);
    q_en = 1'b1;
    drain(2);
    cap_en = '1;
    for (int m = 0; m < 2; m++) begin
      stop_full = (m == 1);
      ovf_exp = 1'b0;
      sample();
      sample();
      cmp("overflow flag", ovf_exp, ovf);
      level();
      drain(DEPTH);
      ovf_clr = 1'b1;
      step(2);
      ovf_clr = 1'b0;
      step(1);
      cmp("overflow flag", 1'b0, ovf);
    end
    sample();
    q_rst = 1'b1;
    step(1);
    q_rst = 1'b0;
    step(4);
    fq.delete();
    level();
    drain(1);
    wr(AXIS_STANDBY_CONTROL_OFS, 8'h2A);
    wr(QUEUE_DATA_PORT_OFS, 8'h33);
    nrst = 1'b0;
    step(3);
    nrst = 1'b1;
    step(4);
    cmp("standby", STANDBY_RST, stby);
    cmp("miso drive", 1'b1, miso_oe_n);
    cmp("two wire addr", 7'h69, two_addr);
    drain(1);
    step(20);
    cmp("pending reads", 16'h0, 16'(exp_q.size()));
    final_report();
  end
endmodule
